// file: core/qpc_defines.vh
`ifndef QPC_DEFINES_VH
`define QPC_DEFINES_VH
// register byte offsets
`define QPC_REG_CTRL 12'h000
`define QPC_REG_STATUS 12'h004
`define QPC_REG_PORT_CFG 12'h008
`define QPC_REG_DSCP_DEF 12'h00c
`define QPC_REG_NET_ADDR 12'h010
`define QPC_REG_DSCP_BASE 12'h100
`define QPC_REG_VLAN_BASE 12'h200
// ctrl bits (write one to act)
`define QPC_CTRL_COMMIT 0
`define QPC_CTRL_WARM 1
`define QPC_CTRL_FACTORY 2
`define QPC_CTRL_KEEP_ADDR 3
// priority levels
`define QPC_LVL_LOW 2'h0
`define QPC_LVL_NORMAL 2'h1
`define QPC_LVL_MEDIUM 2'h2
`define QPC_LVL_HIGH 2'h3
// classification modes
`define QPC_MODE_PORT 2'h0
`define QPC_MODE_DSCP 2'h1
`define QPC_MODE_VLAN 2'h2
// reset values
`define QPC_RST_PORT_CFG 4'hc
`define QPC_RST_DSCP_DEF 2'h3
`define QPC_RST_DSCP_ENT 3'h0
`define QPC_RST_VLAN_MAP 16'hfa50
`define QPC_RST_NET_ADDR 32'h00000000
// warm restart pulse length in cycles
`define QPC_WARM_CYCLES 8'h10
`endif

// file: core/qpc_lookup.v
`timescale 1ns/1ns
`include "qpc_defines.vh"
module qpc_lookup (
  CLK,
  ARST_N,
  mode,
  port_lvl,
  dscp_map,
  dscp_def,
  vlan_map,
  pkt_valid,
  pkt_is_ip,
  pkt_tagged,
  pkt_dscp,
  pkt_pcp,
  out_valid,
  out_lvl
);
  input wire CLK;
  input wire ARST_N;
  input wire [1:0] mode;
  input wire [1:0] port_lvl;
  input wire [191:0] dscp_map;
  input wire [1:0] dscp_def;
  input wire [15:0] vlan_map;
  input wire pkt_valid;
  input wire pkt_is_ip;
  input wire pkt_tagged;
  input wire [5:0] pkt_dscp;
  input wire [2:0] pkt_pcp;
  output reg out_valid;
  output reg [1:0] out_lvl;
  // dscp_map: 64 entries of 3 bits {explicit, level}
  wire [2:0] dscp_ent = dscp_map[pkt_dscp*3 +: 3];
  wire [1:0] vlan_lvl = vlan_map[pkt_pcp*2 +: 2];
  reg [1:0] lvl_next;
  always @* begin
    lvl_next = port_lvl;
    if (mode == `QPC_MODE_DSCP && pkt_is_ip) begin
      lvl_next = dscp_ent[2] ? dscp_ent[1:0] : dscp_def;
    end else if (mode == `QPC_MODE_VLAN && pkt_tagged) begin
      lvl_next = vlan_lvl;
    end
  end
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_valid <= 1'b0;
      out_lvl <= `QPC_LVL_LOW;
    end else begin
      out_valid <= pkt_valid;
      out_lvl <= lvl_next;
    end
  end
endmodule // qpc_lookup

// file: core/qpc_classifier.v
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "qpc_defines.vh"
// Operation
// - per-port mode picks port, DSCP or tag
// - port mode gives port's fixed level
// - DSCP 0..63 looked up in shared table
// - high is the top of four levels
// - tag priority indexes per-port eight-entry table
// - classification settings act only after explicit commit; network address writes act at once
// - warm restart request pulses switch reset
// - factory default restores all, optionally keeping address
module qpc_classifier #(
  parameter NPORTS = 5
) (
  CLK,
  ARST_N,
  PSEL,
  PENABLE,
  PWRITE,
  PADDR,
  PWDATA,
  PRDATA,
  PREADY,
  PSLVERR,
  PKT_VALID,
  PKT_IS_IP,
  PKT_TAGGED,
  PKT_DSCP,
  PKT_PCP,
  PRIO_VALID,
  PRIO_LVL,
  WARM_RESET,
  NET_ADDR
);
  input wire CLK;
  input wire ARST_N;
  input wire PSEL;
  input wire PENABLE;
  input wire PWRITE;
  input wire [11:0] PADDR;
  input wire [31:0] PWDATA;
  output reg [31:0] PRDATA;
  output wire PREADY;
  output wire PSLVERR;
  input wire [NPORTS-1:0] PKT_VALID;
  input wire [NPORTS-1:0] PKT_IS_IP;
  input wire [NPORTS-1:0] PKT_TAGGED;
  input wire [NPORTS*6-1:0] PKT_DSCP;
  input wire [NPORTS*3-1:0] PKT_PCP;
  output wire [NPORTS-1:0] PRIO_VALID;
  output wire [NPORTS*2-1:0] PRIO_LVL;
  output reg WARM_RESET;
  output wire [31:0] NET_ADDR;

  // pending (software view) and live (committed) copies; packets only see live
  reg [NPORTS*4-1:0] pcfg_reg, pcfg_live_reg;
  reg [2:0] dscp_mem [0:63];
  reg [2:0] dscp_live_mem [0:63];
  wire [191:0] dscp_live_flat;
  reg [31:0] rdata_next;
  reg [1:0] ddef_reg, ddef_live_reg;
  reg [NPORTS*16-1:0] vmap_reg, vmap_live_reg;
  reg [31:0] naddr_reg;
  reg [7:0] warm_cnt_reg;
  reg pending_reg;

  wire acc = PSEL & PENABLE;
  wire wr = acc & PWRITE;
  wire in_dscp = PADDR >= `QPC_REG_DSCP_BASE && PADDR < `QPC_REG_DSCP_BASE + 12'h100;
  wire in_vlan = PADDR >= `QPC_REG_VLAN_BASE && PADDR < `QPC_REG_VLAN_BASE + NPORTS*4;
  wire [5:0] dscp_idx = PADDR[7:2];
  wire [2:0] vlan_idx = PADDR[4:2];
  wire is_ctrl = PADDR == `QPC_REG_CTRL;
  wire hit = is_ctrl || PADDR == `QPC_REG_STATUS || PADDR == `QPC_REG_PORT_CFG ||
    PADDR == `QPC_REG_DSCP_DEF || PADDR == `QPC_REG_NET_ADDR || in_dscp || in_vlan;
  wire commit = wr && is_ctrl && PWDATA[`QPC_CTRL_COMMIT];
  wire factory = wr && is_ctrl && PWDATA[`QPC_CTRL_FACTORY];
  wire keep_addr = PWDATA[`QPC_CTRL_KEEP_ADDR];
  wire warm = wr && is_ctrl && PWDATA[`QPC_CTRL_WARM];

  assign PREADY = 1'b1;
  // unmapped addresses answer with an error and change nothing
  assign PSLVERR = acc & ~hit;
  assign NET_ADDR = naddr_reg;

  integer i;
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (i = 0; i < NPORTS; i = i + 1) begin
        pcfg_reg[i*4 +: 4] <= `QPC_RST_PORT_CFG;
        pcfg_live_reg[i*4 +: 4] <= `QPC_RST_PORT_CFG;
        vmap_reg[i*16 +: 16] <= `QPC_RST_VLAN_MAP;
        vmap_live_reg[i*16 +: 16] <= `QPC_RST_VLAN_MAP;
      end
      ddef_reg <= `QPC_RST_DSCP_DEF;
      ddef_live_reg <= `QPC_RST_DSCP_DEF;
      naddr_reg <= `QPC_RST_NET_ADDR;
      pending_reg <= 1'b0;
    end else if (factory) begin
      // defaults apply at once, both copies, so no stale live set lingers
      for (i = 0; i < NPORTS; i = i + 1) begin
        pcfg_reg[i*4 +: 4] <= `QPC_RST_PORT_CFG;
        pcfg_live_reg[i*4 +: 4] <= `QPC_RST_PORT_CFG;
        vmap_reg[i*16 +: 16] <= `QPC_RST_VLAN_MAP;
        vmap_live_reg[i*16 +: 16] <= `QPC_RST_VLAN_MAP;
      end
      ddef_reg <= `QPC_RST_DSCP_DEF;
      ddef_live_reg <= `QPC_RST_DSCP_DEF;
      if (!keep_addr) begin
        naddr_reg <= `QPC_RST_NET_ADDR;
      end
      pending_reg <= 1'b0;
    end else if (commit) begin
      pcfg_live_reg <= pcfg_reg;
      ddef_live_reg <= ddef_reg;
      vmap_live_reg <= vmap_reg;
      pending_reg <= 1'b0;
    end else if (wr) begin
      if (PADDR == `QPC_REG_PORT_CFG) begin
        pcfg_reg <= PWDATA[NPORTS*4-1:0];
        pending_reg <= 1'b1;
      end else if (PADDR == `QPC_REG_DSCP_DEF) begin
        ddef_reg <= PWDATA[1:0];
        pending_reg <= 1'b1;
      end else if (PADDR == `QPC_REG_NET_ADDR) begin
        naddr_reg <= PWDATA;
      end else if (in_dscp) begin
        pending_reg <= 1'b1;
      end else if (in_vlan) begin
        vmap_reg[vlan_idx*16 +: 16] <= PWDATA[15:0];
        pending_reg <= 1'b1;
      end
    end
  end

  // dscp tables live in arrays; factory and commit sweep every entry in one edge
  integer j;
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (j = 0; j < 64; j = j + 1) begin
        dscp_mem[j] <= `QPC_RST_DSCP_ENT;
        dscp_live_mem[j] <= `QPC_RST_DSCP_ENT;
      end
    end else if (factory) begin
      for (j = 0; j < 64; j = j + 1) begin
        dscp_mem[j] <= `QPC_RST_DSCP_ENT;
        dscp_live_mem[j] <= `QPC_RST_DSCP_ENT;
      end
    end else if (commit) begin
      for (j = 0; j < 64; j = j + 1) begin
        dscp_live_mem[j] <= dscp_mem[j];
      end
    end else if (wr && in_dscp) begin
      dscp_mem[dscp_idx] <= PWDATA[2:0];
    end
  end

  // warm restart: fixed-length reset pulse; config survives, unlike factory
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      warm_cnt_reg <= 8'h00;
      WARM_RESET <= 1'b0;
    end else if (warm) begin
      warm_cnt_reg <= `QPC_WARM_CYCLES;
      WARM_RESET <= 1'b1;
    end else if (warm_cnt_reg != 8'h00) begin
      warm_cnt_reg <= warm_cnt_reg - 8'h01;
      WARM_RESET <= warm_cnt_reg != 8'h01;
    end
  end

  always @* begin
    rdata_next = 32'h0;
    if (PADDR == `QPC_REG_STATUS) begin
      rdata_next = {30'h0, WARM_RESET, pending_reg};
    end else if (PADDR == `QPC_REG_PORT_CFG) begin
      rdata_next[NPORTS*4-1:0] = pcfg_reg;
    end else if (PADDR == `QPC_REG_DSCP_DEF) begin
      rdata_next[1:0] = ddef_reg;
    end else if (PADDR == `QPC_REG_NET_ADDR) begin
      rdata_next = naddr_reg;
    end else if (in_dscp) begin
      rdata_next[2:0] = dscp_mem[dscp_idx];
    end else if (in_vlan) begin
      rdata_next[15:0] = vmap_reg[vlan_idx*16 +: 16];
    end
  end

  // read data is captured in the setup cycle so it stands still through the access phase
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= rdata_next;
    end
  end

  // level code 3 is high and ranks above all others downstream
  genvar g;
  generate
    for (g = 0; g < NPORTS; g = g + 1) begin : port
      qpc_lookup u_lookup (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .mode(pcfg_live_reg[g*4+2 +: 2]),
        .port_lvl(pcfg_live_reg[g*4 +: 2]),
        .dscp_map(dscp_live_flat),
        .dscp_def(ddef_live_reg),
        .vlan_map(vmap_live_reg[g*16 +: 16]),
        .pkt_valid(PKT_VALID[g]),
        .pkt_is_ip(PKT_IS_IP[g]),
        .pkt_tagged(PKT_TAGGED[g]),
        .pkt_dscp(PKT_DSCP[g*6 +: 6]),
        .pkt_pcp(PKT_PCP[g*3 +: 3]),
        .out_valid(PRIO_VALID[g]),
        .out_lvl(PRIO_LVL[g*2 +: 2])
      );
    end
  endgenerate

  // flatten the committed dscp table for the per-port lookups
  generate
    for (g = 0; g < 64; g = g + 1) begin : dscp_flat
      assign dscp_live_flat[g*3 +: 3] = dscp_live_mem[g];
    end
  endgenerate
endmodule // qpc_classifier

// file: test/qpc_classifier_props.sv
`timescale 1ns/1ns
`include "qpc_defines.vh"
module qpc_checker #(
  parameter NPORTS = 5
) (
  input wire CLK,
  input wire ARST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PSLVERR,
  input wire [NPORTS-1:0] PKT_VALID,
  input wire [NPORTS-1:0] PRIO_VALID,
  input wire WARM_RESET,
  input wire [31:0] NET_ADDR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire acc = PSEL && PENABLE;
  wire wr_ctrl = acc && PWRITE && PADDR == `QPC_REG_CTRL;
  sequence warm_req;
    wr_ctrl && PWDATA[`QPC_CTRL_WARM];
  endsequence
  // sixteen cycles high, then low again
  sequence warm_pulse;
    WARM_RESET [*8] ##1 WARM_RESET [*8] ##1 !WARM_RESET;
  endsequence
  a_warm_pulse: assert property (warm_req |=> warm_pulse) else $error("warm pulse wrong");
  a_warm_status: assert property (acc && !PWRITE && PADDR == `QPC_REG_STATUS |-> PRDATA[1] == $past(WARM_RESET))
    else $error("status warm bit wrong");
  a_prio_delay: assert property (1 |=> PRIO_VALID == $past(PKT_VALID)) else $error("result timing wrong");
  a_factory_addr: assert property (wr_ctrl && PWDATA[2] && !PWDATA[3] |=> NET_ADDR == 0)
    else $error("address not cleared");
  a_keep_addr: assert property (wr_ctrl && PWDATA[2] && PWDATA[3] |=> $stable(NET_ADDR))
    else $error("address not kept");
  a_addr_write: assert property (acc && PWRITE && PADDR == `QPC_REG_NET_ADDR |=> NET_ADDR == $past(PWDATA))
    else $error("address write lost");
  a_ctrl_reads: assert property (acc && !PWRITE && PADDR == `QPC_REG_CTRL |-> PRDATA == 0)
    else $error("ctrl read not zero");
  a_dscp_mapped: assert property (acc && PADDR[11:8] == 4'h1 |-> !PSLVERR) else $error("dscp entry refused");
  a_vlan_mapped: assert property (acc && PADDR[11:8] == 4'h2 && PADDR[7:0] < 8'h14 |-> !PSLVERR)
    else $error("tag table refused");
endmodule // qpc_checker
bind qpc_classifier qpc_checker #(.NPORTS(NPORTS)) chk (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .PKT_VALID(PKT_VALID),
  .PRIO_VALID(PRIO_VALID), .WARM_RESET(WARM_RESET), .NET_ADDR(NET_ADDR));

// file: test/qos_priority_classifier_test.sv
`timescale 1ns/1ns
`include "qpc_defines.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("wrong value %s exp %h got %h", n, e, g); end end
module qos_priority_classifier_test;
  reg clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd, r;
  reg err;
  reg [4:0] pv = 0, ip = 0, tg = 0, ex;
  reg [29:0] dscp = 0;
  reg [14:0] pcp = 0;
  wire [31:0] prdata, net_addr;
  wire pready, pslverr, warm;
  wire [4:0] prio_valid;
  wire [9:0] prio_lvl;
  integer mismatches = 0, compares = 0, cyc = 0, seed = 37769, p, k;
  reg [4:0] q[$];
  always #4 clk = ~clk;
  qpc_classifier #(.NPORTS(5)) uut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PKT_VALID(pv),
    .PKT_IS_IP(ip), .PKT_TAGGED(tg), .PKT_DSCP(dscp), .PKT_PCP(pcp), .PRIO_VALID(prio_valid),
    .PRIO_LVL(prio_lvl), .WARM_RESET(warm), .NET_ADDR(net_addr));
  task close_out;
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // every port sees the same fields; only the valid bit picks the port
  task send(input [2:0] g, input i, input t, input [5:0] d, input [2:0] c, input [1:0] e);
    @(posedge clk);
    pv <= 5'h1 << g;
    ip <= {5{i}};
    tg <= {5{t}};
    dscp <= {5{d}};
    pcp <= {5{c}};
    q.push_back({g, e});
    @(posedge clk);
    pv <= 0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (k = 0; k < 5; k = k + 1) if (prio_valid[k] === 1'b1) begin
      `CHK("result expected", 1'b1, q.size() != 0)
      if (q.size() != 0) begin
        ex = q.pop_front();
        `CHK("level", ex, {k[2:0], prio_lvl[k*2+:2]})
      end
    end
    if (cyc == 3000) begin
      mismatches = mismatches + 1;
      close_out;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1;
    apb(0, `QPC_REG_VLAN_BASE + 12'h10, 0);
    `CHK("tag table", 16'hfa50, rd[15:0])
    apb(0, `QPC_REG_DSCP_DEF, 0);
    `CHK("dscp def", 2'h3, rd[1:0])
    apb(0, `QPC_REG_CTRL, 0);
    apb(1, 12'h050, 1);
    `CHK("slverr", 1'b1, err)
    for (p = 0; p < 5; p = p + 1) send(p, 1, 1, $random(seed), $random(seed), `QPC_LVL_LOW);
    apb(1, `QPC_REG_PORT_CFG, 32'h92b53);
    apb(1, 12'h164, 7);
    `CHK("slverr", 1'b0, err)
    apb(1, 12'h1f0, 4);
    r = $random(seed);
    apb(1, `QPC_REG_VLAN_BASE + 12'h10, r);
    send(2, 1, 1, 0, 7, `QPC_LVL_LOW);
    apb(0, `QPC_REG_STATUS, 0);
    `CHK("pending", 1'b1, rd[0])
    apb(1, `QPC_REG_CTRL, 1);
    send(0, 1, 1, 25, 7, `QPC_LVL_HIGH);
    send(3, 1, 1, 60, 7, `QPC_LVL_MEDIUM);
    send(1, 1, 0, 25, 0, `QPC_LVL_HIGH);
    send(1, 1, 0, 60, 0, `QPC_LVL_LOW);
    send(1, 1, 0, 63, 0, `QPC_LVL_HIGH);
    send(1, 0, 0, 25, 0, `QPC_LVL_NORMAL);
    send(2, 0, 0, 0, 7, `QPC_LVL_HIGH);
    for (p = 0; p < 8; p = p + 1) send(2, 0, 1, 0, p, p[2:1]);
    for (p = 0; p < 8; p = p + 1) send(4, 0, 1, 0, p, r[2*p+:2]);
    apb(1, `QPC_REG_CTRL, 2);
    apb(0, `QPC_REG_STATUS, 0);
    `CHK("warm", 1'b1, rd[1])
    repeat (20) @(posedge clk);
    r = $random(seed);
    apb(1, `QPC_REG_NET_ADDR, r);
    apb(1, `QPC_REG_CTRL, 32'hc);
    @(posedge clk);
    `CHK("kept addr", r, net_addr)
    apb(0, `QPC_REG_VLAN_BASE + 12'h10, 0);
    `CHK("tag table", 16'hfa50, rd[15:0])
    send(1, 1, 0, 25, 0, `QPC_LVL_LOW);
    apb(1, `QPC_REG_CTRL, 4);
    @(posedge clk);
    `CHK("addr", 32'h0, net_addr)
    repeat (4) @(posedge clk);
    `CHK("pending results", 0, q.size())
    close_out;
  end
endmodule // qos_priority_classifier_test
